// [hdl/tsh_pkg.sv]
// Constants shared by both ends of the time-slot bus and the register map.
// Assumes aclk at 25 MHz and a 1.536 MHz double-rate clock framed at 8 kHz.
package tsh_pkg;
  localparam int CLK_HZ       = 25000000;
  localparam int DRC_HZ       = 1536000;
  localparam int FRAME_HZ     = 8000;
  localparam int DRC_HALF_CYC = CLK_HZ / (2 * DRC_HZ);
  localparam int SLOTS        = 12;
  localparam int UNITS        = 4;

  localparam logic [6:0] FRAME_BITS   = 7'(DRC_HZ / (2 * FRAME_HZ));
  localparam logic [6:0] NO_POS       = 7'h7f;
  localparam logic [6:0] FS_HIGH_BITS = 7'h08;
  localparam logic [3:0] LAST_SLOT    = 4'(SLOTS - 1);
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [7:0] LEAD_PS0     = 8'h02;
  localparam logic [7:0] LEAD_PS1     = 8'h01;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_ENABLE    = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_EVENT     = 8'h0c;
  localparam logic [7:0] REG_SPS_BASE  = 8'h10;
  localparam logic [7:0] REG_DATA_BASE = 8'h20;

  localparam int CTRL_DIS_BIT  = 0;
  localparam int CTRL_BCL_BIT  = 1;
  localparam int CTRL_SWAP_LSB = 2;
  localparam int SPS_PORT_BIT  = 7;

  localparam logic [3:0] CTRL_RESET = 4'h1;
  localparam logic [7:0] SPS_RESET  = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hdl/tsh_bus_if.sv]
// Serial slot bus between the handler and the far-end bus devices.
// Data lines idle high; an enabled driver sets the level, the device's if both ends enable.
`timescale 1ns/10ps
`default_nettype none
interface tsh_bus_if;
  logic frame_sync;
  logic double_rate_clock;
  logic bit_rate_clock;
  logic dev_up_out;
  logic dev_up_oe;
  logic dev_dn_out;
  logic dev_dn_oe;
  logic par_up_out;
  logic par_up_oe;
  logic par_dn_out;
  logic par_dn_oe;
  logic upstream_line;
  logic downstream_line;

  assign upstream_line   = dev_up_oe ? dev_up_out : (par_up_oe ? par_up_out : 1'b1);
  assign downstream_line = dev_dn_oe ? dev_dn_out : (par_dn_oe ? par_dn_out : 1'b1);

  modport device (
    input  frame_sync, double_rate_clock, bit_rate_clock, upstream_line, downstream_line,
    output dev_up_out, dev_up_oe, dev_dn_out, dev_dn_oe
  );
  modport partner (
    output frame_sync, double_rate_clock, bit_rate_clock,
    output par_up_out, par_up_oe, par_dn_out, par_dn_oe,
    input  upstream_line, downstream_line
  );
endinterface
`default_nettype wire

// [hdl/tsh_slot_timer.sv]
// Bit and slot timing recovered from the bus clocks and frame sync.
// Bus inputs are pins from another domain; all three pass two flip-flops first.
`timescale 1ns/10ps
`default_nettype none
module tsh_slot_timer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       frame_sync,
  input  wire logic       double_rate_clock,
  input  wire logic       bit_rate_clock,
  input  wire logic       use_bit_clock,
  output logic            launch,
  output logic            sample,
  output logic [6:0]      bit_pos
);
  import tsh_pkg::*;

  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] prev;
  logic       phase;
  logic       clk_now;
  logic       clk_old;
  logic       fs_rise;
  logic       clk_rise;
  logic       clk_fall;
  logic       new_bit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 3'h0;
      sync <= 3'h0;
      prev <= 3'h0;
    end else begin
      meta <= {frame_sync, double_rate_clock, bit_rate_clock};
      sync <= meta;
      prev <= sync;
    end
  end

  assign clk_now  = use_bit_clock ? sync[0] : sync[1];
  assign clk_old  = use_bit_clock ? prev[0] : prev[1];
  assign fs_rise  = sync[2] & ~prev[2];
  assign clk_rise = clk_now & ~clk_old;
  assign clk_fall = ~clk_now & clk_old;
  // One bit clock period per bit, or two double-rate periods
  assign new_bit  = clk_rise & (use_bit_clock | fs_rise | phase);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 1'b0;
    end else if (clk_rise) begin
      phase <= ~new_bit | use_bit_clock;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_pos <= NO_POS;
    end else if (new_bit) begin
      if (fs_rise) begin
        bit_pos <= 7'h00;
      end else if (bit_pos < FRAME_BITS) begin
        bit_pos <= bit_pos + 7'h01;
      end
    end
  end

  // Registered so bit_pos already names the new bit in the launch cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      launch <= 1'b0;
      sample <= 1'b0;
    end else begin
      launch <= new_bit;
      sample <= clk_fall & (use_bit_clock | phase);
    end
  end
endmodule
`default_nettype wire

// [hdl/tsh_device.sv]
// Slot access handler: four byte units mapped onto the framed slot bus,
// programmed over AXI4-Lite. Assumes the far end supplies clocks and sync.
`timescale 1ns/10ps
`default_nettype none
module tsh_device #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  tsh_bus_if.device              bus,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  import tsh_pkg::*;

  logic [3:0]       ctrl;
  logic [7:0]       enable;
  logic [7:0]       sps [UNITS];
  logic [7:0]       held [UNITS];
  logic [7:0]       outgoing [UNITS];
  logic [7:0]       shift [UNITS];
  logic [UNITS-1:0] evt;
  logic [UNITS-1:0] ovf;
  logic [UNITS-1:0] evt_set;
  logic [UNITS-1:0] ovf_set;
  logic [UNITS-1:0] cap_hit;
  logic [UNITS-1:0] out_hit;
  logic [UNITS-1:0] in_bit;
  logic             launch;
  logic             sample;
  logic [6:0]       bit_pos;
  logic [3:0]       slot;
  logic [2:0]       bitn;
  logic             run;
  logic [1:0]       up_meta;
  logic [1:0]       dn_meta;
  logic             up_s;
  logic             dn_s;

  // Write and read channel state
  logic              aw_hold;
  logic              w_hold;
  logic [7:0]        wr_addr;
  logic [31:0]       wr_data;
  logic              wr_strb0;
  logic              wr_go;
  logic              wr_ok;
  logic [UNITS-1:0]  data_wr;
  logic [UNITS-1:0]  evt_clr;
  logic [UNITS-1:0]  ovf_clr;
  logic [31:0]       rd_val;
  logic              rd_ok;
  logic [7:0]        rd_addr;

  tsh_slot_timer u_timer (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .frame_sync        (bus.frame_sync),
    .double_rate_clock (bus.double_rate_clock),
    .bit_rate_clock    (bus.bit_rate_clock),
    .use_bit_clock     (ctrl[CTRL_BCL_BIT]),
    .launch            (launch),
    .sample            (sample),
    .bit_pos           (bit_pos)
  );

  // Three stages so line data lines up with the registered sample pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_meta <= 2'h3;
      dn_meta <= 2'h3;
      up_s    <= 1'b1;
      dn_s    <= 1'b1;
    end else begin
      up_meta <= {up_meta[0], bus.upstream_line};
      dn_meta <= {dn_meta[0], bus.downstream_line};
      up_s    <= up_meta[1];
      dn_s    <= dn_meta[1];
    end
  end

  assign slot = bit_pos[6:3];
  assign bitn = bit_pos[2:0];
  assign run  = ~ctrl[CTRL_DIS_BIT] & (bit_pos < FRAME_BITS);

  function automatic logic [7:0] wrap_pos(input logic [7:0] v);
    wrap_pos = (v >= {1'b0, FRAME_BITS}) ? v - {1'b0, FRAME_BITS} : v;
  endfunction

  for (genvar i = 0; i < UNITS; i++) begin : g_unit
    logic [7:0] in_sps;
    logic [7:0] lead;
    logic [7:0] base;
    logic [3:0] pre_slot;
    logic       load_hit;

    // Output placement never follows the swap
    assign in_sps   = ctrl[CTRL_SWAP_LSB + i/2] ? sps[i ^ 1] : sps[i];
    // Port select 1 puts output on downstream, input from upstream
    assign in_bit[i] = in_sps[SPS_PORT_BIT] ? up_s : dn_s;
    assign cap_hit[i] = run & sample & enable[2*i] & (slot == in_sps[3:0]);
    assign out_hit[i] = run & enable[2*i+1] & (slot == sps[i][3:0]);
    assign pre_slot = (sps[i][3:0] == 4'h0) ? LAST_SLOT : sps[i][3:0] - 4'h1;
    // Latching a slot ahead keeps b = a+1 and loops to the next frame
    assign load_hit = run & launch & (bitn == 3'h0) & (slot == pre_slot);
    assign lead = sps[i][SPS_PORT_BIT] ? LEAD_PS1 : LEAD_PS0;
    assign base = {1'b0, sps[i][3:0], 3'h0};
    assign evt_set[i] = run & launch & enable[2*i]
                      & ({1'b0, bit_pos} == wrap_pos(base + 8'h08 + lead));
    assign ovf_set[i] = run & launch & enable[2*i+1] & evt[i]
                      & ({1'b0, bit_pos} == wrap_pos(base + {1'b0, FRAME_BITS} - lead));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        shift[i] <= 8'h00;
      end else if (cap_hit[i]) begin
        shift[i] <= {shift[i][6:0], in_bit[i]};
      end
    end

    // Capture beats a software write in the same cycle
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        held[i] <= 8'h00;
      end else if (cap_hit[i] && bitn == LAST_BIT) begin
        held[i] <= {shift[i][6:0], in_bit[i]};
      end else if (data_wr[i]) begin
        held[i] <= wr_data[7:0];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        outgoing[i] <= 8'hff;
      end else if (load_hit) begin
        outgoing[i] <= held[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus.dev_up_oe  <= 1'b0;
      bus.dev_up_out <= 1'b1;
      bus.dev_dn_oe  <= 1'b0;
      bus.dev_dn_out <= 1'b1;
    end else if (!run) begin
      bus.dev_up_oe <= 1'b0;
      bus.dev_dn_oe <= 1'b0;
    end else if (launch) begin
      bus.dev_up_oe  <= 1'b0;
      bus.dev_up_out <= 1'b1;
      bus.dev_dn_oe  <= 1'b0;
      bus.dev_dn_out <= 1'b1;
      for (int k = 0; k < UNITS; k++) begin
        if (out_hit[k] && sps[k][SPS_PORT_BIT]) begin
          bus.dev_dn_oe  <= 1'b1;
          bus.dev_dn_out <= outgoing[k][~bitn];
        end else if (out_hit[k]) begin
          bus.dev_up_oe  <= 1'b1;
          bus.dev_up_out <= outgoing[k][~bitn];
        end
      end
    end
  end

  // Event flags: a set in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt <= '0;
      ovf <= '0;
    end else begin
      evt <= (evt & ~evt_clr) | evt_set;
      ovf <= (ovf & ~ovf_clr) | ovf_set;
    end
  end

  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
  assign wr_go         = aw_hold & w_hold;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_addr       = 8'(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 32'h0;
      wr_strb0 <= 1'b0;
    end else if (wr_go) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        wr_addr <= 8'(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold   <= 1'b1;
        wr_data  <= s_axi_wdata;
        wr_strb0 <= s_axi_wstrb[0];
      end
    end
  end

  always_comb begin
    wr_ok   = 1'b1;
    data_wr = '0;
    evt_clr = '0;
    ovf_clr = '0;
    if (wr_addr[7:4] == REG_DATA_BASE[7:4] && wr_addr[1:0] == 2'h0) begin
      data_wr[wr_addr[3:2]] = wr_go & wr_strb0;
    end else if (wr_addr == REG_EVENT) begin
      evt_clr = {UNITS{wr_go & wr_strb0}} & wr_data[UNITS-1:0];
      ovf_clr = {UNITS{wr_go & wr_strb0}} & wr_data[2*UNITS-1:UNITS];
    end else if (wr_addr != REG_CTRL && wr_addr != REG_ENABLE
                 && !(wr_addr[7:4] == REG_SPS_BASE[7:4] && wr_addr[1:0] == 2'h0)) begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl   <= CTRL_RESET;
      enable <= 8'h00;
      for (int k = 0; k < UNITS; k++) begin
        sps[k] <= SPS_RESET;
      end
    end else if (wr_go && wr_strb0) begin
      if (wr_addr == REG_CTRL) begin
        ctrl <= wr_data[3:0];
      end
      if (wr_addr == REG_ENABLE) begin
        enable <= wr_data[7:0];
      end
      if (wr_addr[7:4] == REG_SPS_BASE[7:4] && wr_addr[1:0] == 2'h0) begin
        sps[wr_addr[3:2]] <= wr_data[7:0] & 8'h8f;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    if (rd_addr == REG_CTRL) begin
      rd_val[3:0] = ctrl;
    end else if (rd_addr == REG_ENABLE) begin
      rd_val[7:0] = enable;
    end else if (rd_addr == REG_STATUS) begin
      rd_val[6:0] = bit_pos;
    end else if (rd_addr == REG_EVENT) begin
      rd_val[2*UNITS-1:0] = {ovf, evt};
    end else if (rd_addr[7:4] == REG_SPS_BASE[7:4] && rd_addr[1:0] == 2'h0) begin
      rd_val[7:0] = sps[rd_addr[3:2]];
    end else if (rd_addr[7:4] == REG_DATA_BASE[7:4] && rd_addr[1:0] == 2'h0) begin
      rd_val[7:0] = held[rd_addr[3:2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [hdl/tsh_partner.sv]
// Far end of the slot bus: makes the clocks and frame sync by dividing
// aclk, drives one chosen slot and records every slot of both lines.
`timescale 1ns/10ps
`default_nettype none
module tsh_partner (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  tsh_bus_if.partner      bus,
  input  wire logic       tx_en,
  input  wire logic [3:0] tx_slot,
  input  wire logic       tx_line,
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] rx_slot,
  input  wire logic       rx_line,
  output logic [7:0]      rx_byte,
  output logic            frame_start
);
  import tsh_pkg::*;

  logic [7:0] half_cnt;
  logic       toggle;
  logic       rise;
  logic       fall;
  logic       phase;
  logic [6:0] bit_pos;
  logic [6:0] nb;
  logic [1:0] up_meta;
  logic [1:0] dn_meta;
  logic [7:0] sh_up;
  logic [7:0] sh_dn;
  logic [7:0] rx_mem [2][SLOTS];

  assign toggle = (half_cnt == 8'(DRC_HALF_CYC - 1));
  assign rise   = toggle & ~bus.double_rate_clock;
  assign fall   = toggle & bus.double_rate_clock;
  assign nb     = (bit_pos >= FRAME_BITS - 7'h01) ? 7'h00 : bit_pos + 7'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt              <= 8'h00;
      bus.double_rate_clock <= 1'b0;
    end else begin
      half_cnt              <= toggle ? 8'h00 : half_cnt + 8'h01;
      bus.double_rate_clock <= bus.double_rate_clock ^ toggle;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase              <= 1'b1;
      bit_pos            <= FRAME_BITS - 7'h01;
      bus.frame_sync     <= 1'b0;
      bus.bit_rate_clock <= 1'b0;
      frame_start        <= 1'b0;
      bus.par_up_oe      <= 1'b0;
      bus.par_up_out     <= 1'b1;
      bus.par_dn_oe      <= 1'b0;
      bus.par_dn_out     <= 1'b1;
    end else begin
      frame_start <= 1'b0;
      if (rise) begin
        phase              <= ~phase;
        bus.bit_rate_clock <= phase;
        if (phase) begin
          bit_pos        <= nb;
          bus.frame_sync <= nb < FS_HIGH_BITS;
          frame_start    <= nb == 7'h00;
          bus.par_up_oe  <= tx_en & ~tx_line & (nb[6:3] == tx_slot);
          bus.par_dn_oe  <= tx_en & tx_line & (nb[6:3] == tx_slot);
          bus.par_up_out <= tx_byte[~nb[2:0]];
          bus.par_dn_out <= tx_byte[~nb[2:0]];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_meta <= 2'h3;
      dn_meta <= 2'h3;
    end else begin
      up_meta <= {up_meta[0], bus.upstream_line};
      dn_meta <= {dn_meta[0], bus.downstream_line};
    end
  end

  // Sample on the falling edge of the second double-rate period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_up <= 8'hff;
      sh_dn <= 8'hff;
    end else if (fall && phase) begin
      sh_up <= {sh_up[6:0], up_meta[1]};
      sh_dn <= {sh_dn[6:0], dn_meta[1]};
    end
  end

  // Memory holds no reset; bytes are valid after the first full frame
  always_ff @(posedge aclk) begin
    if (fall && phase && bit_pos[2:0] == LAST_BIT && bit_pos < FRAME_BITS) begin
      rx_mem[0][bit_pos[6:3]] <= {sh_up[6:0], up_meta[1]};
      rx_mem[1][bit_pos[6:3]] <= {sh_dn[6:0], dn_meta[1]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_byte <= 8'h00;
    end else begin
      rx_byte <= (rx_slot <= LAST_SLOT) ? rx_mem[rx_line][rx_slot] : 8'hff;
    end
  end
endmodule
`default_nettype wire

// [dv/tsh_monitor.sv]
// Checker on the slot bus wires between the handler and the far end.
// Fed the interface signals as plain inputs; single aclk domain.
`timescale 1ns/10ps
`default_nettype none
module tsh_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic frame_sync,
  input wire logic double_rate_clock,
  input wire logic bit_rate_clock,
  input wire logic dev_up_out,
  input wire logic dev_up_oe,
  input wire logic dev_dn_out,
  input wire logic dev_dn_oe,
  input wire logic par_up_oe,
  input wire logic upstream_line
);
  logic [11:0] cnt;
  logic        fs_q;
  logic        seen;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Frame is far beyond a plain delay, so count it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 12'h000;
      fs_q <= 1'b0;
      seen <= 1'b0;
    end else begin
      fs_q <= frame_sync;
      cnt  <= (frame_sync && !fs_q) ? 12'h000 : cnt + 12'h001;
      seen <= seen | (frame_sync & !fs_q);
    end
  end
  sequence s_bit_start;
    $rose(bit_rate_clock) && $rose(double_rate_clock);
  endsequence
  property p_dcl_period;
    $rose(double_rate_clock) |-> ##16 $rose(double_rate_clock);
  endproperty
  a_dcl_period: assert property (p_dcl_period) else $error("bad dcl period");
  property p_bcl;
    $rose(bit_rate_clock) |-> s_bit_start ##32 s_bit_start;
  endproperty
  a_bcl: assert property (p_bcl) else $error("bad bit clock");
  property p_fs_start;
    $rose(frame_sync) |-> s_bit_start ##0 frame_sync [*8];
  endproperty
  a_fs_start: assert property (p_fs_start) else $error("frame start off bit");
  property p_frame_len;
    $rose(frame_sync) && seen |-> cnt == 12'hbff;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad frame length");
  property p_idle;
    !dev_up_oe && !par_up_oe |-> upstream_line;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle high");
  property p_launch;
    dev_up_oe && $changed(dev_up_out) |-> double_rate_clock;
  endproperty
  a_launch: assert property (p_launch) else $error("launch off edge");
  property p_hold;
    dev_dn_oe && $changed(dev_dn_out) |=> (!dev_dn_oe || $stable(dev_dn_out)) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("bit not held");
  property p_oe_rise;
    $rose(dev_dn_oe) |-> double_rate_clock ##1 dev_dn_oe [*8];
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive not held");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Bench: handler and far end joined by the slot bus; registers over AXI4-Lite.
// Far end makes all bus clocks; expected bytes follow from each setup.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import tsh_pkg::*;
  logic        aclk, aresetn, tx_en, tx_line, rx_line, frame_start;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_byte, rx_byte;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb, tx_slot, rx_slot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          num_errors, check_count;
  tsh_bus_if bus ();
  tsh_device tsh_device_i (
    .aclk, .aresetn, .bus, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp);
  tsh_partner tsh_partner_i (
    .aclk, .aresetn, .bus, .tx_en, .tx_slot, .tx_line, .tx_byte, .rx_slot, .rx_line,
    .rx_byte, .frame_start);
  tsh_monitor tsh_monitor_i (
    .aclk, .aresetn, .frame_sync(bus.frame_sync), .double_rate_clock(bus.double_rate_clock),
    .bit_rate_clock(bus.bit_rate_clock), .dev_up_out(bus.dev_up_out),
    .dev_up_oe(bus.dev_up_oe), .dev_dn_out(bus.dev_dn_out), .dev_dn_oe(bus.dev_dn_oe),
    .par_up_oe(bus.par_up_oe), .upstream_line(bus.upstream_line));
  always #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    {ad, wd} = 2'b00;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
      if (s_axi_wvalid && s_axi_wready) wd = 1'b1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  // Far end's record is registered, so let the select settle
  task automatic rx(input logic [3:0] s, input logic l, input logic [7:0] e);
    rx_slot <= s;
    rx_line <= l;
    repeat (3) @(posedge aclk);
    chk(32'(rx_byte), 32'(e));
  endtask
  task automatic frames(input int n);
    repeat (n) @(posedge aclk iff frame_start);
  endtask
  // Mid-bit samples of one upstream slot straight off the wire
  task automatic wire_byte(input int slot, input logic [7:0] e);
    logic [7:0] b;
    b = 8'h00;
    @(posedge aclk iff frame_start);
    repeat (slot * 256 + 16) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      b = {b[6:0], bus.upstream_line};
      repeat (32) @(posedge aclk);
    end
    chk(32'(b), 32'(e));
  endtask
  task automatic t_regs;
    rdc(REG_CTRL, 32'(CTRL_RESET));
    rdc(REG_SPS_BASE + 8'h04, 32'(SPS_RESET));
    wr(REG_SPS_BASE, 32'h0000_008b);
    chk(32'(resp), 32'(RESP_OKAY));
    rdc(REG_SPS_BASE, 32'h0000_008b);
    rd(8'h40);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h40, 32'h0000_0001);
    chk(32'(resp), 32'(RESP_SLVERR));
  endtask
  task automatic t_loop;
    wr(REG_SPS_BASE, 32'h0000_0002);
    wr(REG_ENABLE, 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_0000);
    {tx_slot, tx_line, tx_byte, tx_en} <= {4'h2, 1'b1, 8'h1e, 1'b1};
    frames(3);
    rx(4'h2, 1'b0, 8'h1e);
    rx(4'h3, 1'b0, 8'hff);
    wire_byte(2, 8'h1e);
    rdc(REG_DATA_BASE, 32'h0000_001e);
    frames(1);
    tx_byte <= 8'h2d;
    repeat (1200) @(posedge aclk);
    rx(4'h2, 1'b0, 8'h1e);
    frames(2);
    rx(4'h2, 1'b0, 8'h2d);
    wr(REG_CTRL, 32'h0000_0002);
    tx_byte <= 8'h69;
    frames(3);
    rx(4'h2, 1'b0, 8'h69);
  endtask
  task automatic t_shift;
    wr(REG_SPS_BASE, 32'h0000_0001);
    wr(REG_SPS_BASE + 8'h04, 32'h0000_0084);
    wr(REG_ENABLE, 32'h0000_000c);
    wr(REG_CTRL, 32'h0000_0004);
    {tx_slot, tx_byte} <= {4'h1, 8'h3c};
    frames(2);
    tx_byte <= 8'hc3;
    repeat (1700) @(posedge aclk);
    rx(4'h4, 1'b1, 8'hc3);
    wr(REG_ENABLE, 32'h0000_0008);
    tx_byte <= 8'h55;
    frames(2);
    rx(4'h4, 1'b1, 8'hc3);
    wr(REG_DATA_BASE + 8'h04, 32'h0000_005a);
    frames(2);
    rx(4'h4, 1'b1, 8'h5a);
    wr(REG_CTRL, 32'h0000_0005);
    frames(2);
    rx(4'h4, 1'b1, 8'hff);
    wr(REG_ENABLE, 32'h0000_000c);
    wr(REG_CTRL, 32'h0000_0000);
    frames(3);
    rx(4'h4, 1'b1, 8'hff);
  endtask
  // Unit 1 on slot 4 port 1: event at bit 41, overflow at bit 31
  task automatic t_event;
    frames(1);
    wr(REG_EVENT, 32'h0000_00ff);
    repeat (1400) @(posedge aclk);
    rdc(REG_EVENT, 32'h0000_0002);
    frames(1);
    repeat (1100) @(posedge aclk);
    rdc(REG_EVENT, 32'h0000_0022);
    repeat (300) @(posedge aclk);
    wr(REG_EVENT, 32'h0000_0022);
    frames(1);
    repeat (1100) @(posedge aclk);
    rdc(REG_EVENT, 32'h0000_0000);
  endtask
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {aclk, aresetn, tx_en, tx_line, rx_line, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_byte, tx_slot, rx_slot} = '0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_loop();
    t_shift();
    t_event();
    conclude();
  end
  // Scenarios need about 80k cycles
  initial begin
    repeat (100000) @(posedge aclk);
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
